// ===== core/riat_decode.v
// address decoder: memory regions and peripheral selects
// purely combinational on a byte address from the same clock domain
`timescale 1ns/100ps
`include "riat_consts.vh"

module riat_decode (
  // address
  input wire [`RIAT_AW-1:0] addr,
  // regions
  output wire iram_hit,
  output wire dram_hit,
  output wire p1_hit,
  output wire p2_hit,
  // targets inside the peripheral regions
  output wire cfg_hit,
  output wire per_hit,
  output wire per_wide,
  output wire [`RIAT_SEL_N-1:0] per_sel
);

  function in_rng;
    input [`RIAT_AW-1:0] a;
    input [`RIAT_AW-1:0] lo;
    input [`RIAT_AW-1:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  assign iram_hit = in_rng(addr, `RIAT_IRAM_LO, `RIAT_IRAM_HI);
  assign dram_hit = in_rng(addr, `RIAT_DRAM_LO, `RIAT_DRAM_HI);
  assign p1_hit = in_rng(addr, `RIAT_P1_LO, `RIAT_P1_HI);
  assign p2_hit = in_rng(addr, `RIAT_P2_LO, `RIAT_P2_HI);
  assign cfg_hit = (addr == `RIAT_CFG_ADDR);

  // region one bases
  assign per_sel[`RIAT_SEL_PSC] = in_rng(addr, `RIAT_PSC_LO, `RIAT_PSC_HI);
  assign per_sel[`RIAT_SEL_UART] = in_rng(addr, `RIAT_UART_LO, `RIAT_UART_HI);
  assign per_sel[`RIAT_SEL_T8] = in_rng(addr, `RIAT_T8_LO, `RIAT_T8_HI);
  assign per_sel[`RIAT_SEL_T16A] = in_rng(addr, `RIAT_T16A_LO, `RIAT_T16A_HI);
  assign per_sel[`RIAT_SEL_T16B] = in_rng(addr, `RIAT_T16B_LO, `RIAT_T16B_HI);
  assign per_sel[`RIAT_SEL_T16C] = in_rng(addr, `RIAT_T16C_LO, `RIAT_T16C_HI);
  assign per_sel[`RIAT_SEL_ITC] = in_rng(addr, `RIAT_ITC_LO, `RIAT_ITC_HI);
  assign per_sel[`RIAT_SEL_SPI] = in_rng(addr, `RIAT_SPI_LO, `RIAT_SPI_HI);
  assign per_sel[`RIAT_SEL_I2C] = in_rng(addr, `RIAT_I2C_LO, `RIAT_I2C_HI);
  // region two: the config register is served here, not forwarded
  assign per_sel[`RIAT_SEL_PCT] = in_rng(addr, `RIAT_PCT_LO, `RIAT_PCT_HI);
  assign per_sel[`RIAT_SEL_P2] = p2_hit && !cfg_hit &&
                                 !per_sel[`RIAT_SEL_PCT];

  // gaps select nothing and so never reach a peripheral
  assign per_hit = |per_sel;

  // bus width of the selected peripheral
  assign per_wide = per_sel[`RIAT_SEL_T8] | per_sel[`RIAT_SEL_T16A] |
                    per_sel[`RIAT_SEL_T16B] | per_sel[`RIAT_SEL_T16C] |
                    per_sel[`RIAT_SEL_ITC] | per_sel[`RIAT_SEL_SPI] |
                    per_sel[`RIAT_SEL_I2C] | per_sel[`RIAT_SEL_PCT];

endmodule

// ===== core/riat_ram.v
// single port synchronous ram with byte lanes
// assumes address and write data held stable by the controller
`timescale 1ns/100ps
`include "riat_consts.vh"

module riat_ram #(
  parameter DW = 16,
  parameter AW = 11,
  parameter WORDS = 2048
) (
  // clock
  input wire clk,
  // access
  input wire we,
  input wire [AW-1:0] addr,
  input wire [DW/8-1:0] be,
  input wire [DW-1:0] wdata,
  output reg [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:WORDS-1];
  integer i;

  // read is registered: data is valid one edge after the address
  always @(posedge clk) begin
    for (i = 0; i < DW / 8; i = i + 1) begin
      if (we && be[i]) begin
        mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
      end
    end
    rdata <= mem[addr];
  end

endmodule

// ===== core/riat_top.v
// ram and peripheral access timing: decode, wait states, display ram wait
// assumes an avalon-mm master on clk that holds each request until the
// edge where waitrequest is low; peripherals sit on the same clock
//
// Behaviour
// - internal ram at 0x0 to 0xfff
// - internal ram: read two cycles, write one
// - display ram 0x80000-0x8055f, byte wide, 2-5 cycles
// - display ram usable as plain data storage
// - display ram length is select field plus two
// - select field bits 1:0, reset 0x3, rest zero
// - region one at 0x4000, 1 KB, one cycle
// - region two at 0x5000, 4 KB, three cycles
// - region one byte and halfword peripheral widths
// - region two byte wide, capture timer halfword
// - peripheral select bases in region one
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "riat_consts.vh"

module riat_top (
  // clock and reset
  input wire clk,
  input wire rst,
  // avalon-mm slave
  input wire [`RIAT_AW-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [15:0] avs_writedata,
  input wire [1:0] avs_byteenable,
  output reg [15:0] avs_readdata,
  output wire avs_waitrequest,
  // peripheral register bus
  output wire [`RIAT_AW-1:0] per_addr,
  output wire [`RIAT_SEL_N-1:0] per_sel,
  output wire per_wide,
  output wire per_rd,
  output wire per_wr,
  output wire [15:0] per_wdata,
  output wire [1:0] per_be,
  input wire [15:0] per_rdata
);

  wire iram_hit;
  wire dram_hit;
  wire p1_hit;
  wire p2_hit;
  wire cfg_hit;
  wire per_hit;
  wire req;
  wire done;
  wire [2:0] last_cyc;
  wire [15:0] iram_q;
  wire [7:0] dram_q;
  wire [10:0] dram_idx;
  reg [2:0] cnt_reg;
  reg [2:0] cnt_next;
  reg [`RIAT_CFG_SEL_W-1:0] cfg_reg;
  reg [`RIAT_CFG_SEL_W-1:0] cfg_next;

  riat_decode u_dec (
    .addr(avs_address),
    .iram_hit(iram_hit),
    .dram_hit(dram_hit),
    .p1_hit(p1_hit),
    .p2_hit(p2_hit),
    .cfg_hit(cfg_hit),
    .per_hit(per_hit),
    .per_wide(per_wide),
    .per_sel(per_sel)
  );

  // index of the cycle in which an access completes
  function [2:0] last_of;
    input iram;
    input dram;
    input p1;
    input p2;
    input wr;
    input [`RIAT_CFG_SEL_W-1:0] sel;
    reg [2:0] n;
    begin
      n = `RIAT_CYC_NONE;
      if (iram) begin
        n = wr ? `RIAT_CYC_IRAM_WR : `RIAT_CYC_IRAM_RD;
      end else if (dram) begin
        n = `RIAT_CYC_DRAM_MIN + {1'b0, sel};
      end else if (p1) begin
        n = `RIAT_CYC_P1;
      end else if (p2) begin
        n = `RIAT_CYC_P2;
      end
      last_of = n - 3'h1;
    end
  endfunction

  assign req = avs_read | avs_write;
  assign last_cyc = last_of(iram_hit, dram_hit, p1_hit, p2_hit, avs_write,
                            cfg_reg);

  // hold the master until its region's count has run out
  assign avs_waitrequest = req && (cnt_reg != last_cyc);
  assign done = req && !avs_waitrequest;

  always @* begin
    cnt_next = cnt_reg + 3'h1;
    if (done || !req) begin
      cnt_next = 3'h0;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // wait configuration: byte device, lane 0, takes effect on completion
  always @* begin
    cfg_next = cfg_reg;
    if (done && avs_write && cfg_hit && avs_byteenable[0]) begin
      cfg_next = avs_writedata[`RIAT_CFG_SEL_W-1:0];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= `RIAT_CFG_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // internal ram, halfword wide; debug area stays reachable
  riat_ram #(
    .DW(16),
    .AW(11),
    .WORDS(`RIAT_IRAM_WORDS)
  ) u_iram (
    .clk(clk),
    .we(done && avs_write && iram_hit),
    .addr(avs_address[11:1]),
    .be(avs_byteenable),
    .wdata(avs_writedata),
    .rdata(iram_q)
  );

  // display ram as byte wide general storage
  assign dram_idx = avs_address[10:0];

  riat_ram #(
    .DW(8),
    .AW(11),
    .WORDS(`RIAT_DRAM_WORDS)
  ) u_dram (
    .clk(clk),
    .we(done && avs_write && dram_hit && avs_byteenable[0]),
    .addr(dram_idx),
    .be(1'b1),
    .wdata(avs_writedata[7:0]),
    .rdata(dram_q)
  );

  // peripheral side; byte devices see lane 0 only
  assign per_addr = avs_address;
  assign per_rd = avs_read && per_hit;
  // strobe only on the completing edge, never into a gap
  assign per_wr = done && avs_write && per_hit;
  assign per_wdata = per_wide ? avs_writedata : {8'h00, avs_writedata[7:0]};
  assign per_be = per_wide ? avs_byteenable : {1'b0, avs_byteenable[0]};

  // ram reads are registered, so they are valid by the completing cycle
  always @* begin
    avs_readdata = 16'h0000;
    if (iram_hit) begin
      avs_readdata = iram_q;
    end else if (dram_hit) begin
      avs_readdata = {8'h00, dram_q};
    end else if (cfg_hit) begin
      avs_readdata = {14'h0000, cfg_reg};
    end else if (per_hit) begin
      avs_readdata = per_wide ? per_rdata : {8'h00, per_rdata[7:0]};
    end
  end

endmodule

// ===== inc/riat_consts.vh
// address map, cycle counts and reset values of the access timing block
// definitions only; included by every design file of the block
`ifndef RIAT_CONSTS_VH
`define RIAT_CONSTS_VH

`define RIAT_AW 20

// memory regions, inclusive byte addresses
`define RIAT_IRAM_LO 20'h00000
`define RIAT_IRAM_HI 20'h00FFF
`define RIAT_DBG_LO 20'h00FC0
`define RIAT_DRAM_LO 20'h80000
`define RIAT_DRAM_HI 20'h8055F
`define RIAT_DRAM_WORDS 1376
`define RIAT_IRAM_WORDS 2048

// peripheral regions
`define RIAT_P1_LO 20'h04000
`define RIAT_P1_HI 20'h043FF
`define RIAT_P2_LO 20'h05000
`define RIAT_P2_HI 20'h05FFF

// peripheral selects inside region one
`define RIAT_PSC_LO 20'h04020
`define RIAT_PSC_HI 20'h04020
`define RIAT_UART_LO 20'h04100
`define RIAT_UART_HI 20'h04105
`define RIAT_T8_LO 20'h04200
`define RIAT_T8_HI 20'h04207
`define RIAT_T16A_LO 20'h04220
`define RIAT_T16A_HI 20'h04227
`define RIAT_T16B_LO 20'h04240
`define RIAT_T16B_HI 20'h04247
`define RIAT_T16C_LO 20'h04260
`define RIAT_T16C_HI 20'h04267
`define RIAT_ITC_LO 20'h04300
`define RIAT_ITC_HI 20'h04315
`define RIAT_SPI_LO 20'h04320
`define RIAT_SPI_HI 20'h04327
`define RIAT_I2C_LO 20'h04340
`define RIAT_I2C_HI 20'h04347
// pulse capture timer window in region two, placement arbitrary
`define RIAT_PCT_LO 20'h05800
`define RIAT_PCT_HI 20'h0581F

// display ram wait configuration register
`define RIAT_CFG_ADDR 20'h05321
`define RIAT_CFG_SEL_W 2
`define RIAT_CFG_RST 2'h3

// access lengths in bus cycles
`define RIAT_CYC_IRAM_RD 3'h2
`define RIAT_CYC_IRAM_WR 3'h1
`define RIAT_CYC_DRAM_MIN 3'h2
`define RIAT_CYC_P1 3'h1
`define RIAT_CYC_P2 3'h3
`define RIAT_CYC_NONE 3'h1

// bit positions of the peripheral select vector
`define RIAT_SEL_N 11
`define RIAT_SEL_PSC 0
`define RIAT_SEL_UART 1
`define RIAT_SEL_T8 2
`define RIAT_SEL_T16A 3
`define RIAT_SEL_T16B 4
`define RIAT_SEL_T16C 5
`define RIAT_SEL_ITC 6
`define RIAT_SEL_SPI 7
`define RIAT_SEL_I2C 8
`define RIAT_SEL_P2 9
`define RIAT_SEL_PCT 10

`endif

// ===== verification/riat_per_model.sv
// peripheral model on the per_* bus: one shared data register
// same clock as the block; answers in the same cycle
`timescale 1ns/100ps
module riat_per_model (
  // clock
  input wire clk,
  // request
  input wire per_rd,
  input wire per_wr,
  input wire [15:0] per_wdata,
  // answer
  output wire [15:0] per_rdata
);
  logic [15:0] data_reg = 16'h0000;
  always @(posedge clk)
    if (per_wr) data_reg <= per_wdata;
  // undriven bus must not look like valid data
  assign per_rdata = per_rd ? data_reg : ~data_reg;
endmodule

// ===== verification/riat_top_sva.sv
// wait-state and decode checker for the access timing block
// sees only riat_top ports; bound into every instance
`timescale 1ns/100ps
`include "riat_consts.vh"
module riat_top_sva (
  // clock and reset
  input wire clk,
  input wire rst,
  // watched ports
  input wire [`RIAT_AW-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [15:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [`RIAT_SEL_N-1:0] per_sel,
  input wire per_wr,
  input wire [15:0] avs_writedata,
  input wire [1:0] avs_byteenable,
  input wire [`RIAT_AW-1:0] per_addr,
  input wire per_wide,
  input wire [15:0] per_wdata,
  input wire [1:0] per_be
);
  wire rq = avs_read | avs_write;
  wire [19:0] a = avs_address;
  wire ir = a <= 20'h00FFF;
  wire dr = a >= 20'h80000 && a <= 20'h8055F;
  wire p1 = a >= 20'h04000 && a <= 20'h043FF;
  wire p2 = a >= 20'h05000 && a <= 20'h05FFF;
  reg [2:0] cnt_reg;
  // cycles already stalled in the current access
  always @(posedge clk or posedge rst)
    if (rst) cnt_reg <= 3'h0;
    else if (rq && avs_waitrequest) cnt_reg <= cnt_reg + 3'h1;
    else cnt_reg <= 3'h0;
  // select field as software last wrote it; reset value 0x3
  reg [1:0] cfg_seen;
  always @(posedge clk or posedge rst)
    if (rst) cfg_seen <= 2'h3;
    else if (avs_write && !avs_waitrequest && a == 20'h05321 &&
             avs_byteenable[0]) cfg_seen <= avs_writedata[1:0];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_ir_rd;
    avs_read && ir |-> avs_waitrequest == (cnt_reg == 3'h0);
  endproperty
  a_ir_rd: assert property (p_ir_rd) else $error("iram read length");
  property p_ir_wr; avs_write && ir |-> !avs_waitrequest; endproperty
  a_ir_wr: assert property (p_ir_wr) else $error("iram write length");
  property p_p1; rq && p1 |-> !avs_waitrequest; endproperty
  a_p1: assert property (p_p1) else $error("region one length");
  property p_p2; rq && p2 |-> avs_waitrequest == (cnt_reg < 3'h2); endproperty
  a_p2: assert property (p_p2) else $error("region two length");
  property p_dr_min;
    rq && dr && cnt_reg == 3'h0 |-> avs_waitrequest;
  endproperty
  a_dr_min: assert property (p_dr_min) else $error("display short");
  property p_dr_max;
    rq && dr && cnt_reg == 3'h4 |-> !avs_waitrequest;
  endproperty
  a_dr_max: assert property (p_dr_max) else $error("display long");
  property p_dr_len;
    rq && dr |-> avs_waitrequest == (cnt_reg <= {1'b0, cfg_seen});
  endproperty
  a_dr_len: assert property (p_dr_len) else $error("display length");
  property p_idle; !rq |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("stall while idle");
  property p_psc; rq && a == 20'h04020 |-> per_sel == 11'h001; endproperty
  a_psc: assert property (p_psc) else $error("prescaler select");
  property p_gap;
    avs_read && p1 && per_sel == 11'h000 && !avs_waitrequest
      |-> avs_readdata == 16'h0000;
  endproperty
  a_gap: assert property (p_gap) else $error("gap read not zero");
  property p_pwr; per_wr |-> avs_write && !avs_waitrequest; endproperty
  a_pwr: assert property (p_pwr) else $error("stray write");
  property p_addr; rq |-> per_addr == avs_address; endproperty
  a_addr: assert property (p_addr) else $error("peripheral address");
  property p_uart;
    rq && a >= 20'h04100 && a <= 20'h04105 |-> per_sel == 11'h002;
  endproperty
  a_uart: assert property (p_uart) else $error("uart select");
  property p_t16;
    rq && a >= 20'h04220 && a <= 20'h04227 |-> per_sel == 11'h008;
  endproperty
  a_t16: assert property (p_t16) else $error("timer select");
  property p_wide;
    rq && a >= 20'h04200 && a <= 20'h04347 && per_sel != 11'h000
      |-> per_wide;
  endproperty
  a_wide: assert property (p_wide) else $error("halfword width");
  property p_narrow;
    rq && (a == 20'h04020 || (a >= 20'h04100 && a <= 20'h04105) ||
           (a >= 20'h05000 && a < 20'h05800)) |-> !per_wide;
  endproperty
  a_narrow: assert property (p_narrow) else $error("byte width");
  property p_lane;
    per_wr && !per_wide |-> per_be[1] == 1'b0 && per_wdata[15:8] == 8'h00;
  endproperty
  a_lane: assert property (p_lane) else $error("byte lane");
  c_dr: cover property (rq && dr && cnt_reg == 3'h4);
  c_p2: cover property (rq && p2 && !avs_waitrequest);
  c_gap: cover property (avs_read && p1 && per_sel == 11'h000);
endmodule
bind riat_top riat_top_sva riat_top_sva_inst (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .per_sel(per_sel), .per_wr(per_wr), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .per_addr(per_addr),
  .per_wide(per_wide), .per_wdata(per_wdata), .per_be(per_be));

// ===== verification/riat_top_tb.sv
// self-checking bench for the access timing block
// avalon-mm master tasks; a peripheral model answers the per_* bus
`timescale 1ns/100ps
module riat_top_tb;
  logic clk = 0, rst = 1, avs_read = 0, avs_write = 0;
  logic [19:0] avs_address = 0, per_addr;
  logic [15:0] avs_writedata = 0, avs_readdata, per_wdata, per_rdata;
  logic [1:0] avs_byteenable = 2'h3, per_be;
  logic [10:0] per_sel;
  logic avs_waitrequest, per_wide, per_rd, per_wr;
  integer n_errors = 0, cmp_count = 0, s;
  riat_top riat_top_inst (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .per_addr, .per_sel, .per_wide, .per_rd, .per_wr, .per_wdata, .per_be,
    .per_rdata);
  riat_per_model riat_per_model_inst (.clk, .per_rd, .per_wr, .per_wdata,
    .per_rdata);
  initial begin
    forever #12.5 clk = ~clk;
  end
  task check(input [15:0] seen, input [15:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one access, request held until waitrequest seen low; counts cycles
  task acc(input [19:0] ad, input w, input [15:0] d, input [15:0] eq,
      input [15:0] en);
    logic [15:0] k, q;
    avs_address <= ad;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    k = 16'h0001;
    // outputs are read at the edge, before that edge's updates land
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      k = k + 16'h0001;
      @(posedge clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    check(k, en);
    if (!w) check(q, eq);
    @(posedge clk);
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(20'h80010, 1, 16'h0033, 0, 5);
    acc(20'h80010, 0, 0, 16'h0033, 5);
    acc(20'h05321, 0, 0, 16'h0003, 3);
    for (s = 0; s < 4; s = s + 1) begin
      acc(20'h05321, 1, 16'h00FC | s, 0, 3);
      acc(20'h05321, 0, 0, s, 3);
      acc(20'h8055F, 1, 16'h0040 + s, 0, s + 2);
      acc(20'h8055F, 0, 0, 16'h0040 + s, s + 2);
    end
    $display("test display ram done");
    acc(20'h00FFE, 1, 16'hA55A, 0, 1);
    acc(20'h00FFE, 0, 0, 16'hA55A, 2);
    acc(20'h00000, 1, 16'h1234, 0, 1);
    acc(20'h00000, 0, 0, 16'h1234, 2);
    // upper lane only: config write must be ignored, ram keeps lane 0
    avs_byteenable <= 2'h2;
    acc(20'h05321, 1, 16'h0000, 0, 3);
    acc(20'h05321, 0, 0, 16'h0003, 3);
    acc(20'h00000, 1, 16'hFFFF, 0, 1);
    avs_byteenable <= 2'h3;
    acc(20'h00000, 0, 0, 16'hFF34, 2);
    $display("test internal ram done");
    acc(20'h04101, 1, 16'hC35A, 0, 1);
    acc(20'h04101, 0, 0, 16'h005A, 1);
    acc(20'h04222, 1, 16'hBEEF, 0, 1);
    acc(20'h04050, 1, 16'h7777, 0, 1);
    acc(20'h04222, 0, 0, 16'hBEEF, 1);
    acc(20'h04050, 0, 0, 16'h0000, 1);
    acc(20'h05010, 1, 16'h0012, 0, 3);
    acc(20'h05010, 0, 0, 16'h0012, 3);
    acc(20'h30000, 0, 0, 16'h0000, 1);
    $display("test peripherals done");
    close_out;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors = n_errors + 1;
    close_out;
  end
endmodule
